//--- rtl/stn_node_ctl.sv
// Node identifier, auxiliary offset trim, write blocking and oversample ordering of one stack device.
// Assumes the frame decoder runs on i_clk and hands over decoded register writes and frame ends;
// GPIO, fault and wake levels come from pins and are synchronised here.
//
// Contract
// - Eight 16-bit aux trim registers hold 10-bit signed offsets; no aux gain.
// - Non-volatile store needs both unlock keys loaded, then the store command bit.
// - Node identifier reloads on the first edge after reset release, from non-volatile storage when the stored source is 1.
// - Source bit 0: identifier taken from five GPIO levels at reset and learn.
// - Source 1 with learn bit: upward transmit off one frame, identifier writable.
// - After that one frame, identifier read-only and upward transmit on again.
// - Outside learn mode identifier writes are ignored.
// - Fault while stop-on-fault and balancing: writes discarded for about 2 us.
// - Round-robin bit 0: all oversamples of a channel before the next.
// - Round-robin bit 1: full passes repeat until extra oversamples taken.
// - High wake input level is a wake request.
// - Zero in an aux trim register means no correction.
`timescale 1ns/1ps
module stn_node_ctl #(
   parameter int NUM_CH = stn_pkg::NUM_CH // Cell plus aux channels in a scan
) (
   input wire logic i_clk,                           // 10 MHz device clock
   input wire logic i_arst_n,                        // Async reset, active low
   input wire stn_pkg::stn_wr_t i_wr,                // Decoded register write
   input wire logic i_frame_end,                     // One-cycle pulse at end of each received frame
   input wire logic [7:0] i_rd_addr,                 // Read offset
   input wire logic i_rd_en,                         // Read strobe
   input wire logic [4:0] i_nvm_node_id,             // Stored identifier
   input wire logic i_nvm_id_src,                    // Stored identifier source select
   input wire logic [4:0] i_gpio,                    // GPIO pin levels
   input wire logic i_fault,                         // Fault level, async
   input wire logic i_wake,                          // Wake pin, active high
   input wire logic i_conv_start,                    // Start a conversion scan
   input wire logic i_smp_done,                      // One sample finished
   output logic [15:0] o_rd_data,                    // Read data
   output logic o_rd_valid,                          // Read data valid pulse
   output logic [4:0] o_node_id,                     // Node identifier
   output logic o_up_tx_en,                          // Upward transmitter enable
   output logic o_nvm_store,                         // Store-to-nvm pulse
   output logic [stn_pkg::NUM_AUX-1:0][15:0] o_trim, // Aux offset trims
   output logic [4:0] o_smp_ch,                      // Channel to sample
   output logic o_smp_req,                           // Sampling in progress
   output logic o_wake_req                           // Wake request level
);
   stn_pkg::stn_state_t s_q;
   stn_pkg::stn_state_t s_d;
   logic [4:0] gpio_m_q;
   logic [4:0] gpio_s_q;
   logic [2:0] pin_m_q;
   logic [2:0] pin_s_q;
   logic wr_ok;
   logic [4:0] last_ch;

   assign last_ch = 5'(NUM_CH - 1);

   // No reset on the GPIO stages: they keep sampling through reset, so the load edge sees settled pin levels
   always_ff @(posedge i_clk) begin
      gpio_m_q <= i_gpio;
      gpio_s_q <= gpio_m_q;
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_m_q <= 3'h0;
         pin_s_q <= 3'h0;
      end else begin
         pin_m_q <= {i_wake, i_fault, 1'b0};
         pin_s_q <= pin_m_q;
      end
   end

   // Writes are dropped while the post-fault window runs
   assign wr_ok = i_wr.wr_en && (s_q.blk_cnt == 5'h00);

   always_comb begin
      s_d = s_q;
      s_d.rd_valid = 1'b0;
      s_d.nvm_store = 1'b0;
      s_d.fault_prev = pin_s_q[1];
      unique case (s_q.mode)
         stn_pkg::ST_LOAD: begin
            // First edge after release takes the stored source and, on that same edge, the stored or GPIO identity
            s_d.id_src = i_nvm_id_src;
            s_d.node_id = i_nvm_id_src ? i_nvm_node_id : gpio_s_q;
            s_d.mode = stn_pkg::ST_IDLE;
         end
         stn_pkg::ST_IDLE: begin
            if (i_conv_start) begin
               s_d.mode = stn_pkg::ST_RUN;
               s_d.ch = 5'h00;
               s_d.rep = 3'h0;
               s_d.smp_req = 1'b1;
            end
         end
         stn_pkg::ST_RUN: begin
            if (i_smp_done) begin
               if (s_q.round_robin) begin
                  // Whole passes, repeated
                  if (s_q.ch == last_ch) begin
                     s_d.ch = 5'h00;
                     s_d.rep = s_q.rep + 3'h1;
                     if (s_q.rep == s_q.extra_smp) begin
                        s_d.mode = stn_pkg::ST_IDLE;
                        s_d.smp_req = 1'b0;
                     end
                  end else begin
                     s_d.ch = s_q.ch + 5'h01;
                  end
               end else begin
                  // All oversamples of a channel back to back
                  if (s_q.rep == s_q.extra_smp) begin
                     s_d.rep = 3'h0;
                     s_d.ch = s_q.ch + 5'h01;
                     if (s_q.ch == last_ch) begin
                        s_d.ch = 5'h00;
                        s_d.mode = stn_pkg::ST_IDLE;
                        s_d.smp_req = 1'b0;
                     end
                  end else begin
                     s_d.rep = s_q.rep + 3'h1;
                  end
               end
            end
         end
      endcase

      // Learn mode lasts exactly the frame after the one that armed it
      if (i_frame_end) begin
         if (s_q.learning) begin
            s_d.learning = 1'b0;
         end else if (s_q.learn_arm) begin
            s_d.learn_arm = 1'b0;
            s_d.learning = 1'b1;
         end
      end

      if (s_q.blk_cnt != 5'h00) begin
         s_d.blk_cnt = s_q.blk_cnt - 5'h01;
      end

      if (wr_ok && s_q.mode != stn_pkg::ST_LOAD) begin
         if (i_wr.addr[7:3] == stn_pkg::ADDR_TRIM0[7:3]) begin
            s_d.trim[i_wr.addr[2:0]] = i_wr.data;
         end else begin
            unique case (i_wr.addr)
               stn_pkg::ADDR_NODE_ID: begin
                  if (s_q.learning) begin
                     s_d.node_id = i_wr.data[stn_pkg::ID_BITS-1:0];
                  end
               end
               stn_pkg::ADDR_SETUP: s_d.id_src = i_wr.data[stn_pkg::SETUP_ID_SRC_BIT];
               stn_pkg::ADDR_COMMAND: begin
                  if (i_wr.data[stn_pkg::CMD_AUTO_LEARN_BIT]) begin
                     if (s_q.id_src) begin
                        s_d.learn_arm = 1'b1;
                     end else begin
                        s_d.node_id = gpio_s_q;
                     end
                  end
                  if (i_wr.data[stn_pkg::CMD_NVM_STORE_BIT]
                      && s_q.key_one == stn_pkg::KEY_ONE_VALUE
                      && s_q.key_two == stn_pkg::KEY_TWO_VALUE) begin
                     // Keys are spent by a store so a stray command cannot repeat it
                     s_d.nvm_store = 1'b1;
                     s_d.key_one = stn_pkg::RESET_ZERO;
                     s_d.key_two = stn_pkg::RESET_ZERO;
                  end
               end
               stn_pkg::ADDR_KEY_ONE: s_d.key_one = i_wr.data;
               stn_pkg::ADDR_KEY_TWO: s_d.key_two = i_wr.data;
               stn_pkg::ADDR_BAL_SETUP: s_d.fault_stop = i_wr.data[stn_pkg::BAL_FAULT_STOP_BIT];
               stn_pkg::ADDR_BAL_MASK: s_d.bal_mask = i_wr.data;
               stn_pkg::ADDR_AVG_SETUP: begin
                  s_d.round_robin = i_wr.data[stn_pkg::AVG_ROUND_ROBIN_BIT];
                  s_d.extra_smp = i_wr.data[2:0];
               end
               default: ;
            endcase
         end
      end

      // A fault edge while balancing with stop-on-fault opens the window; a write in that same cycle still lands
      if (pin_s_q[1] && !s_q.fault_prev && s_q.fault_stop && s_q.bal_mask != 16'h0000) begin
         s_d.blk_cnt = 5'(stn_pkg::WR_BLOCK_CYC);
      end

      if (i_rd_en) begin
         s_d.rd_valid = 1'b1;
         if (i_rd_addr[7:3] == stn_pkg::ADDR_TRIM0[7:3]) begin
            s_d.rd_data = s_q.trim[i_rd_addr[2:0]];
         end else begin
            unique case (i_rd_addr)
               stn_pkg::ADDR_NODE_ID: s_d.rd_data = {11'h000, s_q.node_id};
               stn_pkg::ADDR_SETUP: s_d.rd_data = {15'h0000, s_q.id_src};
               stn_pkg::ADDR_COMMAND: s_d.rd_data = {15'h0000, s_q.learn_arm | s_q.learning};
               stn_pkg::ADDR_KEY_ONE: s_d.rd_data = s_q.key_one;
               stn_pkg::ADDR_KEY_TWO: s_d.rd_data = s_q.key_two;
               stn_pkg::ADDR_BAL_SETUP: s_d.rd_data = {15'h0000, s_q.fault_stop};
               stn_pkg::ADDR_BAL_MASK: s_d.rd_data = s_q.bal_mask;
               stn_pkg::ADDR_AVG_SETUP: s_d.rd_data = {12'h000, s_q.round_robin, s_q.extra_smp};
               stn_pkg::ADDR_STATUS: s_d.rd_data = {11'h000, s_q.blk_cnt != 5'h00, pin_s_q[2],
                                                    s_q.smp_req, s_q.learning, s_q.learn_arm};
               default: s_d.rd_data = 16'h0000;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q <= '0; // Trims reset to zero: no correction until loaded
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rd_data = s_q.rd_data;
   assign o_rd_valid = s_q.rd_valid;
   assign o_node_id = s_q.node_id;
   assign o_up_tx_en = !s_q.learning;
   assign o_nvm_store = s_q.nvm_store;
   assign o_trim = s_q.trim;
   assign o_smp_ch = s_q.ch;
   assign o_smp_req = s_q.smp_req;
   assign o_wake_req = pin_s_q[2];
endmodule : stn_node_ctl

//--- rtl/stn_pkg.sv
// Package of the stack node identifier and trim control block.
// Assumes a single 10 MHz device clock; shared by the top module and the bench.
package stn_pkg;
   // Register offsets on the internal register port
   localparam logic [7:0] ADDR_TRIM0 = 8'h00;
   localparam logic [7:0] ADDR_NODE_ID = 8'h10;
   localparam logic [7:0] ADDR_SETUP = 8'h11;
   localparam logic [7:0] ADDR_COMMAND = 8'h12;
   localparam logic [7:0] ADDR_KEY_ONE = 8'h13;
   localparam logic [7:0] ADDR_KEY_TWO = 8'h14;
   localparam logic [7:0] ADDR_BAL_SETUP = 8'h15;
   localparam logic [7:0] ADDR_BAL_MASK = 8'h16;
   localparam logic [7:0] ADDR_AVG_SETUP = 8'h17;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // Field positions
   localparam int SETUP_ID_SRC_BIT = 0;
   localparam int CMD_AUTO_LEARN_BIT = 0;
   localparam int CMD_NVM_STORE_BIT = 1;
   localparam int BAL_FAULT_STOP_BIT = 0;
   localparam int AVG_ROUND_ROBIN_BIT = 3;
   localparam int TRIM_BITS = 10;
   localparam int ID_BITS = 5;
   // Unlock keys: values arbitrary
   localparam logic [15:0] KEY_ONE_VALUE = 16'h5a3c;
   localparam logic [15:0] KEY_TWO_VALUE = 16'hc3a5;
   // Reset values
   localparam logic [15:0] RESET_ZERO = 16'h0000;
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int WR_BLOCK_NS = 2000;
   localparam int WR_BLOCK_CYC = (WR_BLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NUM_AUX = 8;
   localparam int NUM_CH = 24;

   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_IDLE = 2'b01,
      ST_RUN = 2'b11
   } stn_mode_t;

   typedef struct packed {
      logic wr_en;       // Write strobe of a decoded frame
      logic [7:0] addr;  // Register offset
      logic [15:0] data; // Write data
   } stn_wr_t;

   typedef struct packed {
      stn_mode_t mode;
      logic [NUM_AUX-1:0][15:0] trim;
      logic [ID_BITS-1:0] node_id;
      logic id_src;
      logic learn_arm;
      logic learning;
      logic [15:0] key_one;
      logic [15:0] key_two;
      logic nvm_store;
      logic fault_stop;
      logic [15:0] bal_mask;
      logic round_robin;
      logic [2:0] extra_smp;
      logic [4:0] blk_cnt;
      logic fault_prev;
      logic [4:0] ch;
      logic [2:0] rep;
      logic smp_req;
      logic [15:0] rd_data;
      logic rd_valid;
   } stn_state_t;
endpackage : stn_pkg

//--- tb/stn_host_model.sv
// Host side of the chained link, reduced to decoded frames.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps
module stn_host_model (
   input wire logic i_clk, // Clock
   output stn_pkg::stn_wr_t o_wr, // Write
   output logic o_frame_end, // Frame end
   output logic o_rd_en, // Read strobe
   output logic [7:0] o_rd_addr, // Read offset
   input wire logic [15:0] i_rd_data // Read data
);
   initial begin
      o_wr = '0;
      o_frame_end = 1'b0;
      o_rd_en = 1'b0;
      o_rd_addr = 8'h00;
   end
   // Clips suspect offsets, then keeps ten bits
   // Aux gain is the host's job: divide by the stored cell slope, scaled by 256
   function automatic int gain_fix(input int raw, input int slope_q8);
      return (raw * 256) / slope_q8;
   endfunction : gain_fix
   function automatic logic [15:0] sat10(input int v);
      int s;
      s = v > 511 ? 511 : (v < -512 ? -512 : v);
      return {6'h00, 10'(s)};
   endfunction : sat10
   // Idle bus shows inverted values so a stale read cannot pass
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_clk) #1 o_wr = '{1'b1, a, d};
      @(posedge i_clk) #1 o_wr = '{1'b0, ~a, ~d};
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      @(posedge i_clk) #1 o_rd_en = 1'b1;
      o_rd_addr = a;
      @(posedge i_clk) #1 q = i_rd_data;
      o_rd_en = 1'b0;
      o_rd_addr = ~a;
   endtask : rd
   task automatic frame_end;
      @(posedge i_clk) #1 o_frame_end = 1'b1;
      @(posedge i_clk) #1 o_frame_end = 1'b0;
   endtask : frame_end
   task automatic store;
      wr(stn_pkg::ADDR_KEY_ONE, stn_pkg::KEY_ONE_VALUE);
      wr(stn_pkg::ADDR_KEY_TWO, stn_pkg::KEY_TWO_VALUE);
      wr(stn_pkg::ADDR_COMMAND, 16'h0002);
   endtask : store
endmodule : stn_host_model

//--- tb/stn_node_ctl_sva.sv
// Port checker of the node control block.
// Assumes a bind onto stn_node_ctl; one clock domain.
`timescale 1ns/1ps
module stn_node_ctl_sva (
   input wire logic i_clk, // Clock
   input wire logic i_arst_n, // Reset
   input wire stn_pkg::stn_wr_t i_wr, // Write
   input wire logic i_frame_end, // Frame end
   input wire logic i_rd_en, // Read strobe
   input wire logic i_wake, // Wake pin
   input wire logic i_conv_start, // Scan start
   input wire logic i_smp_done, // Sample done
   input wire logic o_rd_valid, // Read valid
   input wire logic [4:0] o_node_id, // Identifier
   input wire logic o_up_tx_en, // Upward transmit
   input wire logic o_nvm_store, // Store pulse
   input wire logic [stn_pkg::NUM_AUX-1:0][15:0] o_trim, // Trims
   input wire logic [4:0] o_smp_ch, // Channel
   input wire logic o_smp_req, // Scan busy
   input wire logic o_wake_req // Wake request
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   logic ld_q;
   logic run_q;
   logic cmd_wr;
   // Masks the load edge and the edge after it, where the identifier changes without a write
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ld_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         ld_q <= 1'b1;
         run_q <= ld_q;
      end
   end
   assign cmd_wr = i_wr.wr_en && i_wr.addr == stn_pkg::ADDR_COMMAND;
   sequence s_rd; i_rd_en ##1 o_rd_valid; endsequence
   sequence s_pulse; o_nvm_store ##1 !o_nvm_store; endsequence
   AST_RD: assert property (i_rd_en |-> s_rd) else $error("read not answered");
   AST_RD_NONE: assert property (!i_rd_en |=> !o_rd_valid) else $error("stray read valid");
   AST_TRIM: assert property (run_q && $changed(o_trim) |-> $past(i_wr.wr_en)) else $error("trim moved");
   AST_ST_CAUSE: assert property ($rose(o_nvm_store) |-> $past(cmd_wr)) else $error("store uncaused");
   AST_ST_PULSE: assert property (o_nvm_store |-> s_pulse) else $error("store too long");
   AST_TX_OFF: assert property ($fell(o_up_tx_en) |-> $past(i_frame_end)) else $error("tx off early");
   AST_TX_ON: assert property ($rose(o_up_tx_en) |-> $past(i_frame_end)) else $error("tx on early");
   AST_ID: assert property (run_q && $changed(o_node_id) |-> $past(i_wr.wr_en)) else $error("id moved");
   AST_GO: assert property (i_conv_start && !o_smp_req |=> o_smp_req && o_smp_ch == 5'h00)
      else $error("scan start");
   AST_HOLD: assert property (o_smp_req && !i_smp_done |=> $stable(o_smp_ch)) else $error("ch moved");
   AST_WAKE: assert property (i_wake [*5] |-> o_wake_req) else $error("wake missed");
endmodule : stn_node_ctl_sva
bind stn_node_ctl stn_node_ctl_sva u_sva (
   .i_clk(i_clk),
   .i_arst_n(i_arst_n),
   .i_wr(i_wr),
   .i_frame_end(i_frame_end),
   .i_rd_en(i_rd_en),
   .i_wake(i_wake),
   .i_conv_start(i_conv_start),
   .i_smp_done(i_smp_done),
   .o_rd_valid(o_rd_valid),
   .o_node_id(o_node_id),
   .o_up_tx_en(o_up_tx_en),
   .o_nvm_store(o_nvm_store),
   .o_trim(o_trim),
   .o_smp_ch(o_smp_ch),
   .o_smp_req(o_smp_req),
   .o_wake_req(o_wake_req)
);

//--- tb/stn_node_ctl_tb.sv
// Self-checking bench of the node control block.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ps
module stn_node_ctl_tb;
   typedef struct { int ofs; logic [15:0] exp; } stn_row_t;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_fault = 1'b0;
   logic i_wake = 1'b0;
   logic i_conv_start = 1'b0;
   logic i_smp_done = 1'b0;
   logic [4:0] i_gpio = 5'h15;
   logic i_nvm_id_src = 1'b1;
   logic [4:0] i_nvm_node_id = 5'h0c;
   stn_pkg::stn_wr_t i_wr;
   logic i_frame_end, i_rd_en, o_rd_valid, o_up_tx_en, o_nvm_store, o_smp_req, o_wake_req;
   logic [7:0] i_rd_addr;
   logic [15:0] o_rd_data, q;
   logic [4:0] o_node_id, o_smp_ch;
   logic [stn_pkg::NUM_AUX-1:0][15:0] o_trim;
   int err_count = 0;
   int cmp_count = 0;
   stn_row_t rows [8] = '{'{0, 16'h0000}, '{511, 16'h01ff}, '{700, 16'h01ff}, '{-512, 16'h0200},
      '{-1, 16'h03ff}, '{-900, 16'h0200}, '{85, 16'h0055}, '{-86, 16'h03aa}};
   always #50 i_clk = ~i_clk;
   stn_node_ctl #(.NUM_CH(3)) u_dut (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_wr(i_wr),
      .i_frame_end(i_frame_end),
      .i_rd_addr(i_rd_addr),
      .i_rd_en(i_rd_en),
      .i_nvm_node_id(i_nvm_node_id),
      .i_nvm_id_src(i_nvm_id_src),
      .i_gpio(i_gpio),
      .i_fault(i_fault),
      .i_wake(i_wake),
      .i_conv_start(i_conv_start),
      .i_smp_done(i_smp_done),
      .o_rd_data(o_rd_data),
      .o_rd_valid(o_rd_valid),
      .o_node_id(o_node_id),
      .o_up_tx_en(o_up_tx_en),
      .o_nvm_store(o_nvm_store),
      .o_trim(o_trim),
      .o_smp_ch(o_smp_ch),
      .o_smp_req(o_smp_req),
      .o_wake_req(o_wake_req)
   );
   stn_host_model u_host (.i_clk, .o_wr(i_wr), .o_frame_end(i_frame_end), .o_rd_en(i_rd_en),
      .o_rd_addr(i_rd_addr), .i_rd_data(o_rd_data));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wrap_up;
      if (err_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   initial begin
      #200000 err_count++;
      wrap_up();
   end
   initial begin
      repeat (2) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      @(posedge i_clk) #1 check(o_node_id, 5'h0c);
      check(o_trim[3], 16'h0000);
      for (int i = 0; i < 8; i++) begin
         u_host.wr(8'(i), u_host.sat10(u_host.gain_fix(rows[i].ofs, 256)));
         check(o_trim[i], rows[i].exp);
         u_host.rd(8'(i), q);
         check(q, rows[i].exp);
      end
      u_host.rd(8'h40, q);
      check(q, 16'h0000);
      u_host.wr(stn_pkg::ADDR_NODE_ID, 16'h0003);
      check(o_node_id, 5'h0c);
      u_host.wr(stn_pkg::ADDR_SETUP, 16'h0000);
      u_host.wr(stn_pkg::ADDR_COMMAND, 16'h0001);
      check(o_node_id, 5'h15);
      u_host.wr(stn_pkg::ADDR_SETUP, 16'h0001);
      u_host.wr(stn_pkg::ADDR_COMMAND, 16'h0001);
      u_host.frame_end();
      u_host.wr(stn_pkg::ADDR_NODE_ID, 16'h0000);
      check(o_node_id, 5'h00);
      check(o_up_tx_en, 1'b0);
      u_host.frame_end();
      @(posedge i_clk) #1 check(o_up_tx_en, 1'b1);
      u_host.wr(stn_pkg::ADDR_NODE_ID, 16'h0007);
      u_host.rd(stn_pkg::ADDR_NODE_ID, q);
      check(q, 16'h0000);
      u_host.wr(stn_pkg::ADDR_COMMAND, 16'h0002);
      check(o_nvm_store, 1'b0);
      u_host.store();
      check(o_nvm_store, 1'b1);
      u_host.wr(stn_pkg::ADDR_BAL_SETUP, 16'h0001);
      u_host.wr(stn_pkg::ADDR_BAL_MASK, 16'h0001);
      i_fault = 1'b1;
      repeat (4) @(posedge i_clk);
      u_host.wr(stn_pkg::ADDR_TRIM0, 16'h0123);
      check(o_trim[0], 16'h0000);
      repeat (20) @(posedge i_clk);
      u_host.wr(stn_pkg::ADDR_TRIM0, 16'h0123);
      check(o_trim[0], 16'h0123);
      for (int rr = 0; rr < 2; rr++) begin
         u_host.wr(stn_pkg::ADDR_AVG_SETUP, rr ? 16'h0009 : 16'h0001);
         @(posedge i_clk) #1 i_conv_start = 1'b1;
         @(posedge i_clk) #1 i_conv_start = 1'b0;
         // Done held high across the loop: one sample finishes on every edge
         i_smp_done = 1'b1;
         for (int k = 0; k < 6; k++) begin
            check(o_smp_ch, 16'(rr ? k % 3 : k / 2));
            @(posedge i_clk) #1;
         end
         i_smp_done = 1'b0;
         check(o_smp_req, 1'b0);
      end
      // Mid-run reset with GPIO as identifier source; trims must come back empty
      i_nvm_id_src = 1'b0;
      i_arst_n = 1'b0;
      repeat (2) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      @(posedge i_clk) #1 check(o_node_id, 5'h15);
      check(o_trim[0], 16'h0000);
      check(o_up_tx_en, 1'b1);
      i_wake = 1'b1;
      repeat (4) @(posedge i_clk);
      #1 check(o_wake_req, 1'b1);
      wrap_up();
   end
endmodule : stn_node_ctl_tb
